// File: rtl/dif_map.svh
`ifndef DIF_MAP_SVH
`define DIF_MAP_SVH

// register byte offsets on the apb bus
`define DIF_FUNC_BASE     8'h00
`define DIF_CTRL          8'h20
`define DIF_STAT          8'h24
`define DIF_HREF          8'h28

// control register field positions
`define DIF_CTRL_PM       0
`define DIF_CTRL_ENC      1
`define DIF_CTRL_FRST     2
`define DIF_CTRL_OLS_LSB  4
`define DIF_CTRL_OLS_MSB  6

// reset values
`define DIF_FUNC_RST      8'h0f
`define DIF_CTRL_RST      8'h00

// input function codes
`define DIF_C_RHOLD       8'h0a
`define DIF_C_UP          8'h10
`define DIF_C_DN          8'h11
`define DIF_C_FS_NO       8'h15
`define DIF_C_M2          8'h16
`define DIF_C_FS_NC       8'h17
`define DIF_C_TMR         8'h18
`define DIF_C_PIDD        8'h19
`define DIF_C_ADS2        8'h1a
`define DIF_C_LOCK        8'h1b
`define DIF_C_SH          8'h1e
`define DIF_C_EF_HI       4'h2
`define DIF_C_OFS1        8'h44
`define DIF_C_OFS3        8'h46
`define DIF_C_UP2         8'h75
`define DIF_C_DN2         8'h76

// indication prefix shown ahead of the terminal number
`define DIF_EF_PREFIX     4'he

// timing
`define DIF_CLK_MHZ       125
`define DIF_SH_MS         100
`define DIF_SW_MS         500

`endif

// File: rtl/dif_pkg.sv
package dif_pkg;
  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_STOP = 3'b010,
    FS_LOCK = 3'b100
  } dif_fs_e;

  typedef enum logic [1:0] {
    EF_RAMP  = 2'b00,
    EF_COAST = 2'b01,
    EF_FAST  = 2'b10,
    EF_ALARM = 2'b11
  } dif_ef_e;

  typedef logic [7:0] dif_code_t;
endpackage

// File: rtl/dif_top.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "dif_map.svh"

// Contract
// - fast stop while running ramps down on the fast stop time
// - restart refused until standstill, fast stop released and run removed
// - code 15 closed or code 17 open means fast stop
// - code 16 open picks motor one set, closed picks motor two
// - motor select change during run raises the run-switch alarm
// - with encoder on both motors the switch waits 500 ms
// - no second motor selection with a permanent magnet motor
// - one overload protection selection serves both motors
// - code 18 feeds the delay timer input
// - code 19 closed disables pid, released resumes it
// - code 1a is accel/decel select bit two beside bit one
// - code 1b open blocks parameter writes, reads still allowed
// - sample/hold held 100 ms samples the analog reference
// - power loss clears the held reference to zero
// - sample/hold with ramp hold, up/down, offset or up2/down2 conflicts
// - codes 20 to 2f make an input an external fault input
// - external fault indication is prefix plus terminal number
// - even codes normally open, odd closed, pairs alternate detection
// - reactions: ramp, coast, fast stop faults, or alarm only
// - fault reset ignored while a run command is present
module dif_top #(
  parameter int unsigned N_IN      = 8,
  parameter int unsigned AW        = 12,
  parameter int unsigned SH_CYCLES = `DIF_SH_MS * `DIF_CLK_MHZ * 1000,
  parameter int unsigned SW_CYCLES = `DIF_SW_MS * `DIF_CLK_MHZ * 1000
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic [N_IN-1:0] din,
  input  wire logic          run_cmd,
  input  wire logic          running,
  input  wire logic          standstill,
  input  wire logic          accdec_sel1,
  input  wire logic [AW-1:0] analog_ref,
  output logic               fast_stop_req,
  output logic               restart_inhibit,
  output logic               motor2_sel,
  output logic               motor_switch_busy,
  output logic               run_alarm,
  output logic               timer_in,
  output logic               pid_disable,
  output logic [1:0]         accdec_set,
  output logic               param_lock,
  output logic [AW-1:0]      held_ref,
  output logic               config_conflict_error,
  output logic               ef_fault,
  output logic [1:0]         ef_stop_mode,
  output logic               ef_alarm,
  output logic [7:0]         external_fault_indication,
  output logic [2:0]         overload_protection_select
);
  localparam int SHW = $clog2(SH_CYCLES + 1);
  localparam int SWW = $clog2(SW_CYCLES + 1);

  dif_pkg::dif_code_t func_q [N_IN];
  logic [7:0]        ctrl_q;
  dif_pkg::dif_fs_e  fs_q;
  logic [N_IN-1:0]   fs_v, m2_v, tmr_v, pid_v, ads_v, lock_v, sh_v;
  logic [N_IN-1:0]   is_sh, is_cf, ef_v;
  logic              fs_act, m2_req, sh_act, frst;
  logic [SHW-1:0]    sh_cnt_q;
  logic              sh_done_q;
  logic [SWW-1:0]    sw_cnt_q;
  logic              ef_hit;
  logic [3:0]        ef_term;
  logic [1:0]        ef_kind;
  logic [3:0]        ef_term_q;
  logic              acc, wr_func, wr_ctrl, wr_hit;
  logic [31:0]       rd_d;

  // per-input decode of the assigned function and contact state
  for (genvar i = 0; i < N_IN; i++) begin : g_in
    dif_pkg::dif_code_t c;
    assign c = func_q[i];
    assign fs_v[i]   = (c == `DIF_C_FS_NO && din[i]) ||
                       (c == `DIF_C_FS_NC && !din[i]);
    assign m2_v[i]   = c == `DIF_C_M2 && din[i];
    assign tmr_v[i]  = c == `DIF_C_TMR && din[i];
    assign pid_v[i]  = c == `DIF_C_PIDD && din[i];
    assign ads_v[i]  = c == `DIF_C_ADS2 && din[i];
    // lockout is active while the contact is open
    assign lock_v[i] = c == `DIF_C_LOCK && !din[i];
    assign sh_v[i]   = c == `DIF_C_SH && din[i];
    assign is_sh[i]  = c == `DIF_C_SH;
    assign is_cf[i]  = c == `DIF_C_RHOLD || c == `DIF_C_UP ||
                       c == `DIF_C_DN || c == `DIF_C_UP2 ||
                       c == `DIF_C_DN2 ||
                       (c >= `DIF_C_OFS1 && c <= `DIF_C_OFS3);
    // odd code inverts, bit 1 gates on run
    assign ef_v[i]   = c[7:4] == `DIF_C_EF_HI && (din[i] ^ c[0]) &&
                       (!c[1] || running);
  end

  assign fs_act = |fs_v;
  assign sh_act = |sh_v;
  // selection forced to motor one for magnet motors
  assign m2_req = |m2_v && !ctrl_q[`DIF_CTRL_PM];

  // lowest numbered terminal wins when several faults are present
  always_comb begin
    ef_hit  = 1'b0;
    ef_term = 4'h0;
    ef_kind = 2'h0;
    for (int j = N_IN - 1; j >= 0; j--) begin
      if (ef_v[j]) begin
        ef_hit  = 1'b1;
        ef_term = 4'(j + 1);
        // code bits 3:2 choose the reaction
        ef_kind = func_q[j][3:2];
      end
    end
  end

  // apb decode: registers answer one cycle after setup
  assign acc     = psel && penable && pready;
  assign wr_func = paddr[7:5] == 3'h0 && 32'(paddr[4:2]) < N_IN;
  assign wr_ctrl = paddr == `DIF_CTRL;
  assign wr_hit  = wr_func || wr_ctrl;

  always_comb begin
    rd_d = 32'h0;
    if (wr_func) begin
      rd_d = {24'h0, func_q[paddr[4:2]]};
    end else if (wr_ctrl) begin
      rd_d = {24'h0, ctrl_q};
    end else if (paddr == `DIF_STAT) begin
      rd_d = {12'h0, ef_term_q, ef_stop_mode, ef_fault, ef_alarm,
              config_conflict_error, run_alarm, motor2_sel, param_lock,
              5'h0, fs_q};
    end else if (paddr == `DIF_HREF) begin
      rd_d = 32'(held_ref);
    end
  end

  // bus answer flops; writes refused under lockout report an error
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0 : rd_d;
        pslverr <= !(wr_hit || paddr == `DIF_STAT ||
                     paddr == `DIF_HREF) ||
                   (pwrite && (param_lock || !wr_hit));
      end
    end
  end

  // function select and control registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < N_IN; k++) begin
        func_q[k] <= `DIF_FUNC_RST;
      end
      ctrl_q <= `DIF_CTRL_RST;
    end else begin
      ctrl_q[`DIF_CTRL_FRST] <= 1'b0;
      // writes blocked while locked, reads still served
      if (acc && pwrite && !param_lock) begin
        if (wr_func) begin
          func_q[paddr[4:2]] <= pwdata[7:0];
        end else if (wr_ctrl) begin
          ctrl_q <= pwdata[7:0];
        end
      end
    end
  end
  assign frst = ctrl_q[`DIF_CTRL_FRST];

  // simple level functions straight to output flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_in                   <= 1'b0;
      pid_disable                <= 1'b0;
      accdec_set                 <= 2'h0;
      param_lock                 <= 1'b0;
      config_conflict_error      <= 1'b0;
      overload_protection_select <= 3'h0;
    end else begin
      timer_in    <= |tmr_v;
      pid_disable <= |pid_v;
      // two select bits pick one of four ramp sets
      accdec_set  <= {|ads_v, accdec_sel1};
      param_lock  <= |lock_v;
      config_conflict_error <= |is_sh && |is_cf;
      // one selection shared by both motors
      overload_protection_select <=
        ctrl_q[`DIF_CTRL_OLS_MSB:`DIF_CTRL_OLS_LSB];
    end
  end

  // fast stop sequence; lock stage keeps restart refused
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fs_q            <= dif_pkg::FS_IDLE;
      fast_stop_req   <= 1'b0;
      restart_inhibit <= 1'b0;
    end else begin
      case (fs_q)
        dif_pkg::FS_IDLE: begin
          // ramp on the fast stop time
          if (fs_act && running) begin
            fs_q            <= dif_pkg::FS_STOP;
            fast_stop_req   <= 1'b1;
            restart_inhibit <= 1'b1;
          end
        end
        dif_pkg::FS_STOP: begin
          if (standstill) begin
            fs_q          <= dif_pkg::FS_LOCK;
            fast_stop_req <= 1'b0;
          end
        end
        dif_pkg::FS_LOCK: begin
          // all three conditions release the interlock
          if (standstill && !fs_act && !run_cmd) begin
            fs_q            <= dif_pkg::FS_IDLE;
            restart_inhibit <= 1'b0;
          end
        end
        default: begin
          fs_q            <= dif_pkg::FS_IDLE;
          fast_stop_req   <= 1'b0;
          restart_inhibit <= 1'b0;
        end
      endcase
    end
  end

  // motor selection: never switches under run, alarms instead
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      motor2_sel        <= 1'b0;
      motor_switch_busy <= 1'b0;
      run_alarm         <= 1'b0;
      sw_cnt_q          <= '0;
    end else if (m2_req == motor2_sel) begin
      motor_switch_busy <= 1'b0;
      sw_cnt_q          <= '0;
      run_alarm         <= run_alarm && running;
    end else if (running) begin
      // request differs from the applied motor during run
      run_alarm         <= 1'b1;
      motor_switch_busy <= 1'b0;
      sw_cnt_q          <= '0;
    end else if (ctrl_q[`DIF_CTRL_ENC] &&
                 sw_cnt_q != SWW'(SW_CYCLES - 1)) begin
      // encoder motors settle before the new set applies
      motor_switch_busy <= 1'b1;
      sw_cnt_q          <= sw_cnt_q + 1'b1;
      run_alarm         <= 1'b0;
    end else begin
      motor2_sel        <= m2_req;
      motor_switch_busy <= 1'b0;
      sw_cnt_q          <= '0;
      run_alarm         <= 1'b0;
    end
  end

  // sample/hold: one sample per assertion once held long enough
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // power loss leaves the reference at zero
      held_ref  <= '0;
      sh_cnt_q  <= '0;
      sh_done_q <= 1'b0;
    end else if (!sh_act) begin
      sh_cnt_q  <= '0;
      sh_done_q <= 1'b0;
    end else if (!sh_done_q) begin
      if (sh_cnt_q == SHW'(SH_CYCLES - 1)) begin
        // take the analog reference after the hold time
        held_ref  <= analog_ref;
        sh_done_q <= 1'b1;
      end else begin
        sh_cnt_q <= sh_cnt_q + 1'b1;
      end
    end
  end

  // external faults latch until reset; alarms follow the contact
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ef_fault                  <= 1'b0;
      ef_stop_mode              <= 2'h0;
      ef_alarm                  <= 1'b0;
      ef_term_q                 <= 4'h0;
      external_fault_indication <= 8'h0;
    end else begin
      ef_alarm <= ef_hit && ef_kind == dif_pkg::EF_ALARM;
      if (ef_hit && ef_kind != dif_pkg::EF_ALARM && !ef_fault) begin
        // fault types stop the drive in their own way
        ef_fault                  <= 1'b1;
        ef_stop_mode              <= ef_kind;
        ef_term_q                 <= ef_term;
        external_fault_indication <= {`DIF_EF_PREFIX, ef_term};
      end else if (frst && !run_cmd && ef_fault && !ef_hit) begin
        // reset honoured only without a run command
        ef_fault                  <= 1'b0;
        ef_term_q                 <= 4'h0;
        external_fault_indication <= 8'h0;
      end else if (!ef_fault) begin
        ef_term_q                 <= ef_hit ? ef_term : 4'h0;
        external_fault_indication <=
          ef_hit ? {`DIF_EF_PREFIX, ef_term} : 8'h0;
      end
    end
  end

  a_fs_enter: assert property (@(posedge clk) disable iff (sys_rst)
    fs_q == dif_pkg::FS_IDLE && fs_act && running
    |=> fast_stop_req && restart_inhibit)
    else $error("fast stop not started");

  a_fs_interlock: assert property (@(posedge clk) disable iff (sys_rst)
    restart_inhibit && (run_cmd || fs_act || !standstill)
    |=> restart_inhibit)
    else $error("restart released too early");

  a_m2_pm: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(motor2_sel) |-> !$past(ctrl_q[`DIF_CTRL_PM]))
    else $error("motor two chosen for magnet motor");

  a_run_alarm: assert property (@(posedge clk) disable iff (sys_rst)
    running && m2_req != motor2_sel |=> run_alarm && $stable(motor2_sel))
    else $error("run-switch alarm missing");

  a_pid_off: assert property (@(posedge clk) disable iff (sys_rst)
    |pid_v |=> pid_disable)
    else $error("pid not disabled");

  a_lock_write: assert property (@(posedge clk) disable iff (sys_rst)
    acc && pwrite && param_lock && wr_ctrl |-> pslverr ##1 $stable(ctrl_q))
    else $error("write passed under lockout");

  a_sh_sample: assert property (@(posedge clk) disable iff (sys_rst)
    held_ref != $past(held_ref)
    |-> $past(sh_cnt_q) == SHW'(SH_CYCLES - 1) && $past(sh_act))
    else $error("reference changed without sample");

  a_cfg_conflict: assert property (@(posedge clk) disable iff (sys_rst)
    |is_sh && |is_cf |=> config_conflict_error)
    else $error("conflict not flagged");

  a_reset_run: assert property (@(posedge clk) disable iff (sys_rst)
    ef_fault && run_cmd |=> ef_fault)
    else $error("fault cleared with run present");

  a_ef_latch: assert property (@(posedge clk) disable iff (sys_rst)
    !ef_fault ##1 ef_fault
    |-> external_fault_indication[7:4] == `DIF_EF_PREFIX &&
        external_fault_indication[3:0] != 4'h0)
    else $error("fault indication wrong");
endmodule

// File: verification/dif_contacts.sv
`timescale 1ns/100ps

// far-side contact bank: switches and fault contacts of outside equipment
module dif_contacts #(
  parameter int unsigned N = 8
) (
  input  wire logic         clk,
  output logic [N-1:0]      din
);
  // every contact starts open so no function sees a spurious closure
  initial din = '0;

  task automatic press(input int i, input logic closed);
    @(posedge clk);
    din[i] <= closed;
  endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
`include "dif_map.svh"

module tb;
  localparam int unsigned SH = 20;
  localparam int unsigned SW = 50;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [7:0]  din;
  logic        run_cmd;
  logic        running;
  logic        standstill;
  logic        accdec_sel1;
  logic [11:0] analog_ref;
  logic        fsr, inh, m2, busy, ralm, tmr, pidd, lock, cfe;
  logic        eff, efa;
  logic [1:0]  ads, efm;
  logic [11:0] href;
  logic [7:0]  efi;
  logic [2:0]  ols;
  int          fails;
  int          checks_done;

  dif_top #(.SH_CYCLES(SH), .SW_CYCLES(SW)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .din(din), .run_cmd(run_cmd),
    .running(running), .standstill(standstill),
    .accdec_sel1(accdec_sel1), .analog_ref(analog_ref),
    .fast_stop_req(fsr), .restart_inhibit(inh), .motor2_sel(m2),
    .motor_switch_busy(busy), .run_alarm(ralm), .timer_in(tmr),
    .pid_disable(pidd), .accdec_set(ads), .param_lock(lock),
    .held_ref(href), .config_conflict_error(cfe), .ef_fault(eff),
    .ef_stop_mode(efm), .ef_alarm(efa),
    .external_fault_indication(efi), .overload_protection_select(ols));

  dif_contacts #(.N(8)) u_sw (.clk(clk), .din(din));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // reads at an edge see the values settled before that edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic eexp);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(e, eexp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic eexp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(e, eexp);
  endtask

  function automatic logic [7:0] fa(input int i);
    return 8'(`DIF_FUNC_BASE + 4 * i);
  endfunction

  task automatic t_regs();
    rd(fa(0), 32'h0000000f, 1'b0);
    rd(`DIF_CTRL, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(`DIF_HREF, 32'h1, 1'b1);
    // overload select is shared by both motors
    wr(`DIF_CTRL, 32'h50, 1'b0);
    wt(3);
    chk(ols, 3'h5);
    wr(`DIF_CTRL, 32'h0, 1'b0);
    $display("test regs done");
  endtask

  task automatic t_fast();
    running <= 1'b1;
    run_cmd <= 1'b1;
    wr(fa(0), `DIF_C_FS_NO, 1'b0);
    u_sw.press(0, 1'b1);
    wt(3);
    chk(fsr, 1'b1);
    chk(inh, 1'b1);
    standstill <= 1'b1;
    running <= 1'b0;
    wt(3);
    chk(fsr, 1'b0);
    u_sw.press(0, 1'b0);
    wt(3);
    chk(inh, 1'b1);
    rd(`DIF_STAT, 32'h4, 1'b0);
    run_cmd <= 1'b0;
    wt(3);
    chk(inh, 1'b0);
    // close the contact and swap codes while stopped, so code 15
    // never sees a closed contact during run
    u_sw.press(0, 1'b1);
    wr(fa(0), `DIF_C_FS_NC, 1'b0);
    standstill <= 1'b0;
    running <= 1'b1;
    run_cmd <= 1'b1;
    wt(3);
    chk(fsr, 1'b0);
    u_sw.press(0, 1'b0);
    wt(3);
    chk(fsr, 1'b1);
    wr(fa(0), `DIF_FUNC_RST, 1'b0);
    standstill <= 1'b1;
    running <= 1'b0;
    run_cmd <= 1'b0;
    wt(4);
    standstill <= 1'b0;
    $display("test fast stop done");
  endtask

  task automatic t_motor();
    wr(fa(1), `DIF_C_M2, 1'b0);
    u_sw.press(1, 1'b1);
    wt(3);
    chk(m2, 1'b1);
    running <= 1'b1;
    u_sw.press(1, 1'b0);
    wt(3);
    chk(ralm, 1'b1);
    chk(m2, 1'b1);
    running <= 1'b0;
    u_sw.press(1, 1'b1);
    wt(3);
    chk(ralm, 1'b0);
    wr(`DIF_CTRL, 32'h2, 1'b0);
    u_sw.press(1, 1'b0);
    wt(5);
    chk(busy, 1'b1);
    chk(m2, 1'b1);
    wt(SW);
    chk(m2, 1'b0);
    chk(busy, 1'b0);
    wr(`DIF_CTRL, 32'h1, 1'b0);
    u_sw.press(1, 1'b1);
    wt(3);
    chk(m2, 1'b0);
    wr(`DIF_CTRL, 32'h0, 1'b0);
    wr(fa(1), `DIF_FUNC_RST, 1'b0);
    $display("test motor done");
  endtask

  task automatic t_misc();
    logic [7:0] cc[8];
    cc = '{8'h0a, 8'h10, 8'h11, 8'h44, 8'h45, 8'h46, 8'h75, 8'h76};
    wr(fa(2), `DIF_C_TMR, 1'b0);
    wr(fa(3), `DIF_C_PIDD, 1'b0);
    wr(fa(4), `DIF_C_ADS2, 1'b0);
    accdec_sel1 <= 1'b1;
    u_sw.press(2, 1'b1);
    u_sw.press(3, 1'b1);
    u_sw.press(4, 1'b1);
    wt(3);
    chk({tmr, pidd, ads}, 4'hf);
    u_sw.press(3, 1'b0);
    u_sw.press(4, 1'b0);
    u_sw.press(2, 1'b0);
    wt(3);
    chk({tmr, pidd, ads}, 4'h1);
    u_sw.press(5, 1'b1);
    wr(fa(5), `DIF_C_LOCK, 1'b0);
    u_sw.press(5, 1'b0);
    wt(3);
    chk(lock, 1'b1);
    wr(fa(2), 32'h0f, 1'b1);
    wr(`DIF_CTRL, 32'h10, 1'b1);
    rd(fa(2), 32'h18, 1'b0);
    rd(fa(5), 32'h1b, 1'b0);
    u_sw.press(5, 1'b1);
    wt(3);
    chk(ols, 3'h0);
    wr(fa(5), `DIF_FUNC_RST, 1'b0);
    analog_ref <= 12'h5a3;
    wr(fa(6), `DIF_C_SH, 1'b0);
    u_sw.press(6, 1'b1);
    wt(SH / 2);
    chk(href, 12'h0);
    wt(SH);
    chk(href, 12'h5a3);
    u_sw.press(6, 1'b0);
    foreach (cc[k]) begin
      wr(fa(7), cc[k], 1'b0);
      wt(3);
      chk(cfe, 1'b1);
    end
    wr(fa(7), `DIF_FUNC_RST, 1'b0);
    wt(3);
    chk(cfe, 1'b0);
    wr(fa(6), `DIF_FUNC_RST, 1'b0);
    rd(`DIF_HREF, 32'h5a3, 1'b0);
    // power loss while stopped after a sample: the held reference must come back as zero
    sys_rst <= 1'b1;
    wt(2);
    sys_rst <= 1'b0;
    wt(1);
    chk(href, 12'h0);
    $display("test misc done");
  endtask

  task automatic t_ext();
    logic [7:0] c;
    for (int k = 0; k < 16; k++) begin
      c = 8'h20 + 8'(k);
      running <= 1'b0;
      run_cmd <= 1'b0;
      u_sw.press(7, c[0]);
      wr(fa(7), c, 1'b0);
      if (c[1]) begin
        u_sw.press(7, !c[0]);
        wt(3);
        chk({eff, efa}, 2'h0);
        u_sw.press(7, c[0]);
      end
      running <= 1'b1;
      run_cmd <= 1'b1;
      u_sw.press(7, !c[0]);
      wt(3);
      chk(efa, c[3:2] == 2'h3);
      chk(eff, c[3:2] != 2'h3);
      if (c[3:2] != 2'h3) begin
        chk(efm, c[3:2]);
        chk(efi, 8'he8);
      end
      u_sw.press(7, c[0]);
      wr(`DIF_CTRL, 32'h4, 1'b0);
      wt(3);
      chk(eff, c[3:2] != 2'h3);
      run_cmd <= 1'b0;
      running <= 1'b0;
      wr(`DIF_CTRL, 32'h4, 1'b0);
      wt(3);
      chk({eff, efa}, 2'h0);
      // neutral code first, so the next contact level raises nothing
      wr(fa(7), `DIF_FUNC_RST, 1'b0);
    end
    $display("test external fault done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog at 20000 cycles, well above the several hundred cycles the tests need
  initial begin
    #(8 * 20000);
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {run_cmd, running, standstill, accdec_sel1} = '0;
    analog_ref = '0;
    wt(2);
    sys_rst <= 1'b0;
    t_regs();
    t_fast();
    t_motor();
    t_misc();
    t_ext();
    wrap_up();
  end
endmodule
